// file: rtl/cfr_pkg.sv
package cfr_pkg;
  // system clock rate
  localparam int          CLK_HZ          = 40_000_000;
  // failure threshold: 1 kHz nominal, accepted band 500 Hz to 1.5 kHz
  localparam int          FAIL_FREQ_HZ    = 1000;
  // one nominal threshold period in cycles of sys_clk
  localparam int          FAIL_WIN_CYC    = CLK_HZ / FAIL_FREQ_HZ;
  localparam int          WIN_W           = 16;
  localparam logic [15:0] FAIL_WIN_CNT    = 16'(FAIL_WIN_CYC);
  // register map, byte addresses
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_CLEAR      = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_EN     = 4'hC;
  // control field positions
  localparam int          CTRL_SEL_LSB    = 0;
  localparam int          CTRL_PRIMARY_FAIL_DETECT_ENABLE_BIT  = 4;
  localparam int          CTRL_WDT_OSC_FAIL_DETECT_ENABLE_BIT  = 5;
  localparam int          CTRL_WDTOSC_BIT = 6;
  localparam int          CTRL_FORCED_BIT = 8;
  localparam int          CTRL_ACTWDT_BIT = 9;
  // status event bits
  localparam int          EV_PRIM_FAIL    = 0;
  localparam int          EV_WDT_FAIL     = 1;
  localparam int          EV_SWITCHED     = 2;
  // clock source encodings
  localparam logic [1:0]  SRC_IPO         = 2'h0;
  localparam logic [1:0]  SRC_EXT         = 2'h1;
  localparam logic [1:0]  SRC_WDT         = 2'h2;
  localparam logic [1:0]  SRC_XTAL        = 2'h3;
  // reset values
  localparam logic [1:0]  SEL_RST         = 2'h0;
  localparam logic        WDTOSC_RST      = 1'b1;
endpackage

// file: rtl/cfr_freq_mon.sv
`timescale 1ns/100ps
// watches a sampled clock for a rising edge in each fixed window; flags too-slow
module cfr_freq_mon
  import cfr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic mon_clk,
  output logic      fail
);
  logic             s1_q, s2_q, s3_q;
  logic [WIN_W-1:0] win_q, win_d;
  logic             seen_q, seen_d;
  logic             fail_q, fail_d;

  // two-stage synchroniser plus edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= mon_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // window: no rising edge in one threshold period means failure
  always_comb begin
    win_d  = win_q;
    seen_d = seen_q;
    fail_d = 1'b0;
    if (!en) begin
      win_d  = '0;
      seen_d = 1'b0;
    end else begin
      if (s2_q && !s3_q) seen_d = 1'b1;
      if (win_q == FAIL_WIN_CNT - 16'h0001) begin
        win_d  = '0;
        fail_d = !(seen_q || (s2_q && !s3_q));
        seen_d = 1'b0;
      end else begin
        win_d = win_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_q  <= '0;
      seen_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      win_q  <= win_d;
      seen_q <= seen_d;
      fail_q <= fail_d;
    end
  end

  assign fail = fail_q;
endmodule

// file: rtl/cfr_clock_failure_recovery.sv
`timescale 1ns/100ps
module cfr_clock_failure_recovery
  import cfr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        prim_clk,
  input  wire logic        wdt_osc_clk,
  input  wire logic        wdt_reset_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             use_wdt_clk,
  output logic             fail_nmi,
  output logic             irq
);
  logic [1:0]  sel_q, sel_d;
  logic        primary_fail_detect_enable_q, primary_fail_detect_enable_d;
  logic        wdt_osc_fail_detect_enable_q, wdt_osc_fail_detect_enable_d;
  logic        wdtosc_q, wdtosc_d;
  logic        forced_q, forced_d;
  logic        nmi_q, nmi_d;
  logic [2:0]  stat_q, stat_d;
  logic [2:0]  ien_q, ien_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        prim_fail, wdt_fail;
  logic        wr_ctrl, wr_clr, wr_ien, can_fall;
  logic [2:0]  ev;

  // primary source and watchdog oscillator monitors
  cfr_freq_mon u_prim_mon (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (primary_fail_detect_enable_q && !forced_q),
    .mon_clk (prim_clk),
    .fail    (prim_fail)
  );

  cfr_freq_mon u_wdt_mon (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (wdt_osc_fail_detect_enable_q && wdtosc_q),
    .mon_clk (wdt_osc_clk),
    .fail    (wdt_fail)
  );

  // bus decode; one wait state then ack
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_ctrl = avs_write && ack_q && avs_address == ADDR_CTRL;
  assign wr_clr  = avs_write && ack_q && avs_address == ADDR_CLEAR;
  assign wr_ien  = avs_write && ack_q && avs_address == ADDR_IRQ_EN;
  // fallback only with the watchdog osc enabled and not already the selected source
  assign can_fall = wdtosc_q && sel_q != SRC_WDT;

  // control, fallback and event state
  always_comb begin
    sel_d    = sel_q;
    primary_fail_detect_enable_d  = primary_fail_detect_enable_q;
    wdt_osc_fail_detect_enable_d  = wdt_osc_fail_detect_enable_q;
    wdtosc_d = wdtosc_q;
    forced_d = forced_q;
    nmi_d    = 1'b0;
    ev       = '0;
    ev[EV_PRIM_FAIL] = prim_fail;
    ev[EV_WDT_FAIL]  = wdt_fail;
    if (wr_ctrl) begin
      // a source write ends the forced state unless a fallback lands in the same cycle; enables apply at once
      sel_d    = avs_writedata[CTRL_SEL_LSB +: 2];
      primary_fail_detect_enable_d  = avs_writedata[CTRL_PRIMARY_FAIL_DETECT_ENABLE_BIT];
      wdt_osc_fail_detect_enable_d  = avs_writedata[CTRL_WDT_OSC_FAIL_DETECT_ENABLE_BIT];
      wdtosc_d = avs_writedata[CTRL_WDTOSC_BIT];
      forced_d = 1'b0;
    end
    if (prim_fail) begin
      nmi_d = 1'b1;
      if (can_fall) begin
        forced_d = 1'b1;
        ev[EV_SWITCHED] = 1'b1;
      end
    end
    // sticky status: set wins over clear
    stat_d = (stat_q & ~(wr_clr ? avs_writedata[2:0] : 3'h0)) | ev;
    ien_d  = wr_ien ? avs_writedata[2:0] : ien_q;
    rdata_d = '0;
    if (avs_read && !ack_q) begin
      case (avs_address)
        ADDR_CTRL: begin
          rdata_d[CTRL_SEL_LSB +: 2]  = sel_q;
          rdata_d[CTRL_PRIMARY_FAIL_DETECT_ENABLE_BIT]     = primary_fail_detect_enable_q;
          rdata_d[CTRL_WDT_OSC_FAIL_DETECT_ENABLE_BIT]     = wdt_osc_fail_detect_enable_q;
          rdata_d[CTRL_WDTOSC_BIT]    = wdtosc_q;
          rdata_d[CTRL_FORCED_BIT]    = forced_q;
          rdata_d[CTRL_ACTWDT_BIT]    = use_wdt_clk;
        end
        ADDR_STATUS: rdata_d[2:0] = stat_q;
        ADDR_IRQ_EN: rdata_d[2:0] = ien_q;
        default:     rdata_d = '0;
      endcase
    end else if (ack_q) begin
      rdata_d = rdata_q;
    end
    ack_d = (avs_read || avs_write) && !ack_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_q    <= SEL_RST;
      primary_fail_detect_enable_q  <= 1'b0;
      wdt_osc_fail_detect_enable_q  <= 1'b0;
      wdtosc_q <= WDTOSC_RST;
      forced_q <= 1'b0;
      nmi_q    <= 1'b0;
      stat_q   <= '0;
      ien_q    <= '0;
      rdata_q  <= '0;
      ack_q    <= 1'b0;
    end else begin
      sel_q    <= sel_d;
      primary_fail_detect_enable_q  <= primary_fail_detect_enable_d;
      wdt_osc_fail_detect_enable_q  <= wdt_osc_fail_detect_enable_d;
      wdtosc_q <= wdtosc_d;
      forced_q <= forced_d;
      nmi_q    <= nmi_d;
      stat_q   <= stat_d;
      ien_q    <= ien_d;
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
    end
  end

  // outputs
  assign use_wdt_clk  = forced_q || sel_q == SRC_WDT;
  assign fail_nmi     = nmi_q;
  assign irq          = |(stat_q & ien_q);
  assign avs_readdata = rdata_q;

  // checks

  // a failure with a usable fallback forces the watchdog clock
  a_fail_forces_wdt: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail && can_fall && !wr_ctrl |=> forced_q && use_wdt_clk)
    else $error("fallback did not engage");

  // no fallback with the watchdog oscillator off
  a_no_fall_wdtoff: assert property (@(posedge sys_clk) disable iff (rst)
    !forced_q && !wdtosc_q |=> !forced_q)
    else $error("fallback with watchdog osc off");

  // no fallback when the watchdog already is the source
  a_no_fall_wdtsel: assert property (@(posedge sys_clk) disable iff (rst)
    !forced_q && sel_q == SRC_WDT |=> !forced_q)
    else $error("fallback while watchdog is source");

  // failure event is a single-cycle pulse
  a_fail_nmi_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail |=> fail_nmi ##1 !fail_nmi)
    else $error("failure event not one pulse");

  // vector request only after a detected failure
  a_nmi_has_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(fail_nmi) |-> $past(prim_fail))
    else $error("failure event without cause");

  // forced state only left by a control write
  a_forced_holds: assert property (@(posedge sys_clk) disable iff (rst)
    forced_q && !wr_ctrl |=> forced_q)
    else $error("forced source dropped");

  // a control write with no failure ends the forced state
  a_wrsel_release: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl && !prim_fail |=> !forced_q)
    else $error("source write kept forced state");

  // fallback needs no watchdog reset function
  a_resetfn_indep: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail && wdtosc_q && sel_q != SRC_WDT && !wdt_reset_en
    && !wr_ctrl |=> forced_q)
    else $error("fallback needs watchdog reset");

  // primary failure lands in status
  a_status_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail |=> stat_q[EV_PRIM_FAIL])
    else $error("primary failure not latched");

  // a waiting request is answered on the next cycle
  a_ack_next: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");

  // no wait state without a request
  a_idle_no_wait: assert property (@(posedge sys_clk) disable iff (rst)
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest while idle");

  // acknowledge lasts one cycle
  a_ack_single: assert property (@(posedge sys_clk) disable iff (rst)
    ack_q |=> !ack_q)
    else $error("acknowledge held too long");

  // source field takes the written value
  a_sel_written: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl |=> sel_q == $past(avs_writedata[CTRL_SEL_LSB +: 2]))
    else $error("source select not written");

  // primary detect enable takes the written value
  a_primary_fail_detect_enable_written: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl |=> primary_fail_detect_enable_q == $past(avs_writedata[CTRL_PRIMARY_FAIL_DETECT_ENABLE_BIT]))
    else $error("primary detect enable not written");

  // watchdog detect enable takes the written value
  a_wdt_osc_fail_detect_enable_written: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl |=> wdt_osc_fail_detect_enable_q == $past(avs_writedata[CTRL_WDT_OSC_FAIL_DETECT_ENABLE_BIT]))
    else $error("watchdog detect enable not written");

  // watchdog oscillator enable takes the written value
  a_wdtosc_written: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl |=> wdtosc_q == $past(avs_writedata[CTRL_WDTOSC_BIT]))
    else $error("watchdog osc enable not written");

  // interrupt enable takes the written value
  a_ien_written: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ien |=> ien_q == $past(avs_writedata[2:0]))
    else $error("interrupt enable not written");

  // write-one clears the primary status bit
  a_clear_prim: assert property (@(posedge sys_clk) disable iff (rst)
    wr_clr && avs_writedata[EV_PRIM_FAIL] && !prim_fail
    |=> !stat_q[EV_PRIM_FAIL])
    else $error("primary status not cleared");

  // write-one clears the watchdog status bit
  a_clear_wdt: assert property (@(posedge sys_clk) disable iff (rst)
    wr_clr && avs_writedata[EV_WDT_FAIL] && !wdt_fail
    |=> !stat_q[EV_WDT_FAIL])
    else $error("watchdog status not cleared");

  // an event in the clear cycle still sets
  a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail && wr_clr |=> stat_q[EV_PRIM_FAIL])
    else $error("clear beat a failure event");

  // disabled detector stays quiet
  a_mon_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !primary_fail_detect_enable_q |=> !prim_fail)
    else $error("failure while detect disabled");

  // primary detector paused while forced
  a_mon_paused: assert property (@(posedge sys_clk) disable iff (rst)
    forced_q |=> !prim_fail)
    else $error("failure while forced");

  // watchdog detector off with its oscillator off
  a_wdtmon_off: assert property (@(posedge sys_clk) disable iff (rst)
    !wdtosc_q |=> !wdt_fail)
    else $error("watchdog failure with osc off");

  // watchdog failure lands in status
  a_wdt_latch: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_fail |=> stat_q[EV_WDT_FAIL])
    else $error("watchdog failure not latched");

  // a switch-over is logged
  a_switch_logged: assert property (@(posedge sys_clk) disable iff (rst)
    prim_fail && can_fall |=> stat_q[EV_SWITCHED])
    else $error("switch-over not latched");

  // vector request only from the primary detector
  a_nmi_only_prim: assert property (@(posedge sys_clk) disable iff (rst)
    !prim_fail |=> !fail_nmi)
    else $error("failure event without primary fail");

  // status read returns the status register
  a_rd_status: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && !ack_q && avs_address == ADDR_STATUS
    |=> avs_readdata[2:0] == $past(stat_q))
    else $error("status read wrong");

  // control read shows the forced state
  a_rd_forced: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && !ack_q && avs_address == ADDR_CTRL
    |=> avs_readdata[CTRL_FORCED_BIT] == $past(forced_q))
    else $error("forced flag read wrong");

  // unmapped read gives zero
  a_rd_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && !ack_q && avs_address == 4'h2
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  // read data stand through the answer cycle
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
    ack_q |=> avs_readdata == $past(avs_readdata))
    else $error("read data moved in answer cycle");
endmodule

// file: dv/cfr_osc_model.sv
`timescale 1ns/100ps
// primary source and watchdog oscillator; each stands still when stopped
module cfr_osc_model (
  input  wire logic prim_run,
  input  wire logic wdt_run,
  output logic      prim_clk,
  output logic      wdt_osc_clk
);
  // primary at 100 kHz, far above the failure threshold
  initial begin
    prim_clk = 1'b0;
    forever #5000 if (prim_run) prim_clk = ~prim_clk;
  end
  // watchdog oscillator at 10 kHz, slow but alive
  initial begin
    wdt_osc_clk = 1'b0;
    forever #50000 if (wdt_run) wdt_osc_clk = ~wdt_osc_clk;
  end
endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench
  import cfr_pkg::*;
;
  logic        sys_clk, rst, prim_run, wdt_reset_en;
  logic        prim_clk, wdt_osc_clk, avs_read, avs_write;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, ien;
  logic        avs_waitrequest, use_wdt_clk, fail_nmi, irq;
  int          n_mismatch, checks_done, i;

  cfr_osc_model osc_u (.prim_run(prim_run), .wdt_run(1'b1),
    .prim_clk(prim_clk), .wdt_osc_clk(wdt_osc_clk));
  cfr_clock_failure_recovery dut_u (.sys_clk(sys_clk), .rst(rst),
    .prim_clk(prim_clk), .wdt_osc_clk(wdt_osc_clk),
    .wdt_reset_en(wdt_reset_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .use_wdt_clk(use_wdt_clk),
    .fail_nmi(fail_nmi), .irq(irq));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one bus cycle; held until waitrequest is seen low
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk("bus edges", n, 2);
    @(posedge sys_clk);
  endtask

  // bounded wait for the failure pulse
  task automatic wait_nmi();
    for (i = 0; i < 41000 && fail_nmi !== 1'b1; i++) @(negedge sys_clk);
    chk("fail_nmi", fail_nmi, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // irq expected from status and enable
  function automatic logic exp_irq(logic [31:0] st, logic [31:0] en);
    return |(st & en);
  endfunction

  initial begin
    #(25 * 95000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    {rst, prim_run, avs_read, avs_write} = 4'b1100;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(32'h16EC));
    wdt_reset_en = 1'($urandom);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl reset", rd, 32'h40);
    bus(0, 4'h2, 0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    // detector on, watchdog oscillator off, primary dies
    prim_run <= 1'b0;
    repeat (400) @(posedge sys_clk);
    bus(1, ADDR_IRQ_EN, 32'h7);
    bus(1, ADDR_CTRL, 32'h10);
    wait_nmi();
    chk("no switch", use_wdt_clk, 1'b0);
    chk("irq", irq, 1'b1);
    bus(0, ADDR_STATUS, 0);
    chk("status", rd & 32'h5, 32'h1);
    bus(1, ADDR_IRQ_EN, 32'h0);
    chk("irq masked", irq, 1'b0);
    bus(1, ADDR_CLEAR, 32'h7);
    ien = $urandom & 32'h7;
    bus(1, ADDR_IRQ_EN, ien);
    chk("irq cleared", irq, 1'b0);
    $display("test no fallback done");
    // watchdog oscillator on; next window forces the switch
    bus(1, ADDR_CTRL, 32'h50);
    wait_nmi();
    chk("switched", use_wdt_clk, 1'b1);
    bus(0, ADDR_STATUS, 0);
    chk("status", rd, 32'h5);
    chk("irq rand", irq, exp_irq(32'h5, ien));
    bus(0, ADDR_CTRL, 0);
    chk("forced", (rd >> 8) & 32'h3, 32'h3);
    repeat (200) @(posedge sys_clk);
    chk("held", use_wdt_clk, 1'b1);
    bus(1, ADDR_CTRL, 32'h43);
    #1;
    chk("released", use_wdt_clk, 1'b0);
    $display("test fallback done");
    end_sim();
  end
endmodule
